// >>> rtl/delay_if.sv
// Connection between the evaluator and one switch-in/dropout delay unit.
// Assumes the evaluator drives the tick and the undelayed state.
interface delay_if;
  import limit_logic_pkg::*;
  logic             tick;
  logic             z;
  logic [DLY_W-1:0] rise_dly;
  logic [DLY_W-1:0] fall_dly;
  logic             d_next;
  logic             d_state;

  modport owner (
    output tick, z, rise_dly, fall_dly,
    input  d_next, d_state
  );
  modport unit (
    input  tick, z, rise_dly, fall_dly,
    output d_next, d_state
  );
endinterface

// >>> rtl/delay_unit.sv
// Switch-in and dropout delay for one second-level state, counted in evaluation ticks.
// Assumes the tick is a one-cycle pulse from the evaluator's clock domain.
module delay_unit (
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  delay_if.unit     dl
);
  import limit_logic_pkg::*;

  logic [DLY_W-1:0] cnt_q;
  logic             d_q;
  logic             differ;
  logic             apply;
  logic [DLY_W-1:0] dly;

  // A pending change restarts its count whenever the state flips back before it applies.
  always_comb begin
    differ    = dl.z != d_q;
    dly       = dl.z ? dl.rise_dly : dl.fall_dly;
    apply     = differ && (cnt_q >= dly);
    dl.d_next = apply ? dl.z : d_q;
  end

  assign dl.d_state = d_q;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      d_q <= 1'b0;
    end else if (dl.tick) begin
      d_q <= dl.d_next;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
    end else if (dl.tick) begin
      if (!differ || apply) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  a_zero_pass: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    dl.tick && differ && dly == '0 |=> d_q == $past(dl.z))
    else $error("Zero delay did not pass the change in the same pass.");

  a_delay_wait: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    dl.tick && differ && cnt_q < dly |=> d_q == $past(d_q))
    else $error("Delayed state changed before its delay elapsed.");

endmodule

// >>> rtl/limit_logic_evaluator.sv
// Limit comparators, two-level gate network, delays and alarm outputs, evaluated per tick.
// Assumes limit values and thresholds come from same-clock logic; digital inputs are pins.
module limit_logic_evaluator #(
  parameter int unsigned MAX_GAP_CYCLES = limit_logic_pkg::MAX_GAP_CYC
) (
  input  wire logic                              mclk_i,
  input  wire logic                              resetn_i,
  input  wire logic                              tick_i,
  input  wire limit_logic_pkg::val_vec_t         value_i,
  input  wire limit_logic_pkg::val_vec_t         on_thr_i,
  input  wire limit_logic_pkg::val_vec_t         off_thr_i,
  input  wire logic [limit_logic_pkg::N_DIN-1:0] digin_i,
  input  wire limit_logic_pkg::gate_vec_t        l1_type_i,
  input  wire limit_logic_pkg::l1_sel_t          l1_sel_i,
  input  wire limit_logic_pkg::l1_used_t         l1_used_i,
  input  wire limit_logic_pkg::gate_vec_t        l2_type_i,
  input  wire limit_logic_pkg::l2_sel_t          l2_sel_i,
  input  wire limit_logic_pkg::l2_used_t         l2_used_i,
  input  wire limit_logic_pkg::dly_vec_t         rise_dly_i,
  input  wire limit_logic_pkg::dly_vec_t         fall_dly_i,
  input  wire logic [limit_logic_pkg::N_CH-1:0]  latch_en_i,
  input  wire logic [limit_logic_pkg::N_CH-1:0]  follow_inv_i,
  input  wire logic                              alarm_rst_req_i,
  input  wire logic                              rst_int_en_i,
  input  wire logic [limit_logic_pkg::SEL_W-1:0] rst_int_sel_i,
  output logic [limit_logic_pkg::N_LIM-1:0]      limit_state_o,
  output logic [limit_logic_pkg::N_LIM-1:0]      hour_run_o,
  output logic [limit_logic_pkg::N_CH-1:0]       first_level_state_o,
  output logic [limit_logic_pkg::N_CH-1:0]       second_level_state_o,
  output logic [limit_logic_pkg::N_CH-1:0]       delayed_state_o,
  output logic [limit_logic_pkg::N_CH-1:0]       output_state_o,
  output logic [limit_logic_pkg::N_CH-1:0]       follow_state_o,
  output logic                                   eval_o
);
  import limit_logic_pkg::*;

  function automatic logic gate_eval(input logic [3:0] v, input logic [3:0] used,
                                     input gate_t t);
    logic [3:0] f1;
    logic [3:0] f0;
    logic       r;
    f1 = v | ~used;
    f0 = v & used;
    unique case (t)
      G_AND:   r = &f1;
      G_NAND:  r = ~&f1;
      G_OR:    r = |f0;
      G_NOR:   r = ~|f0;
      G_XOR:   r = $onehot(f0);
      G_XNOR:  r = (&f1) | (~|f0);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic [N_DIN-1:0] din_s1_q;
  logic [N_DIN-1:0] din_s2_q;
  logic [N_DIN-1:0] din_s3_q;
  logic [N_DIN-1:0] din_q;
  logic [GAP_W-1:0] gap_q;
  logic             eval;
  logic [N_LIM-1:0] lim_q;
  logic [N_LIM-1:0] lim_d;
  logic [N_LIM-1:0] lim_upper;
  logic [N_CH-1:0]  y_q;
  logic [N_CH-1:0]  y_d;
  logic [N_CH-1:0]  z_q;
  logic [N_CH-1:0]  z_d;
  logic [N_CH-1:0]  d_cur;
  logic [N_CH-1:0]  d_d;
  logic [N_CH-1:0]  a_q;
  logic [N_CH-1:0]  a_d;
  logic [N_CH-1:0]  s_q;
  logic [N_SRC-1:0] src_old;
  logic             rst_pend_q;
  logic             rst_now;

  // Pins pass three flops; a level counts once the last two agree.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      din_s1_q <= '0;
      din_s2_q <= '0;
      din_s3_q <= '0;
      din_q    <= '0;
    end else begin
      din_s1_q <= digin_i;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
      for (int i = 0; i < N_DIN; i++) begin
        if (din_s2_q[i] == din_s3_q[i]) begin
          din_q[i] <= din_s3_q[i];
        end
      end
    end
  end

  // A missing line-cycle tick is replaced so that passes never drift apart too far.
  assign eval = tick_i || (gap_q == GAP_W'(MAX_GAP_CYCLES - 1));

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_q <= '0;
    end else if (eval) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_q + 1'b1;
    end
  end

  always_comb begin
    for (int i = 0; i < N_LIM; i++) begin
      lim_upper[i] = on_thr_i[i] >= off_thr_i[i];
      lim_d[i]     = lim_q[i];
      if (lim_upper[i]) begin
        if (value_i[i] > on_thr_i[i]) begin
          lim_d[i] = 1'b1;
        end else if (value_i[i] < off_thr_i[i]) begin
          lim_d[i] = 1'b0;
        end
      end else begin
        if (value_i[i] < on_thr_i[i]) begin
          lim_d[i] = 1'b1;
        end else if (value_i[i] > off_thr_i[i]) begin
          lim_d[i] = 1'b0;
        end
      end
    end
  end

  assign src_old = {SRC_UNUSED, a_q, d_cur, z_q, y_q, din_q, lim_q};

  // Gates see this pass's limits; first-level gates also see earlier first-level gates, second-level gates all first-level gates; older states otherwise.
  always_comb begin
    logic [N_SRC-1:0] src;
    logic [3:0]       v;
    src = '0;
    v   = '0;
    y_d = y_q;
    for (int k = 0; k < N_CH; k++) begin
      src = {SRC_UNUSED, a_q, d_cur, z_q, y_d, din_q, lim_d};
      for (int j = 0; j < L1_INPUTS; j++) begin
        v[j] = src[l1_sel_i[k][j]];
      end
      v[3]   = 1'b0;
      y_d[k] = gate_eval(v, {1'b0, l1_used_i[k]}, l1_type_i[k]);
    end
    src = {SRC_UNUSED, a_q, d_cur, z_q, y_d, din_q, lim_d};
    for (int k = 0; k < N_CH; k++) begin
      for (int j = 0; j < L2_INPUTS; j++) begin
        v[j] = src[l2_sel_i[k][j]];
      end
      z_d[k] = gate_eval(v, l2_used_i[k], l2_type_i[k]);
    end
  end

  for (genvar c = 0; c < N_CH; c++) begin : g_dly
    delay_if dif ();
    assign dif.tick     = eval;
    assign dif.z        = z_d[c];
    assign dif.rise_dly = rise_dly_i[c];
    assign dif.fall_dly = fall_dly_i[c];
    assign d_d[c]       = dif.d_next;
    assign d_cur[c]     = dif.d_state;
    delay_unit u_dly (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .dl       (dif)
    );
  end

  // A reset request is held until the next pass consumes it.
  assign rst_now = alarm_rst_req_i || rst_pend_q ||
                   (rst_int_en_i && src_old[rst_int_sel_i]);

  always_comb begin
    for (int c = 0; c < N_CH; c++) begin
      if (latch_en_i[c]) begin
        a_d[c] = d_d[c] || (a_q[c] && !rst_now);
      end else begin
        a_d[c] = d_d[c];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_pend_q <= 1'b0;
    end else if (eval) begin
      rst_pend_q <= 1'b0;
    end else if (alarm_rst_req_i) begin
      rst_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lim_q <= '0;
      y_q   <= '0;
      z_q   <= '0;
      a_q   <= '0;
      s_q   <= '0;
    end else if (eval) begin
      lim_q <= lim_d;
      y_q   <= y_d;
      z_q   <= z_d;
      a_q   <= a_d;
      s_q   <= a_d ^ follow_inv_i;
    end
  end

  assign limit_state_o        = lim_q;
  assign hour_run_o           = lim_q;
  assign first_level_state_o  = y_q;
  assign second_level_state_o = z_q;
  assign delayed_state_o      = d_cur;
  assign output_state_o       = a_q;
  assign follow_state_o       = s_q;
  assign eval_o               = eval;

  a_upper_trip: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && on_thr_i[0] >= off_thr_i[0] && value_i[0] > on_thr_i[0] |=> lim_q[0])
    else $error("Upper limit did not switch on above its ON threshold.");

  a_lower_trip: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && on_thr_i[1] < off_thr_i[1] && value_i[1] < on_thr_i[1] |=> lim_q[1])
    else $error("Lower limit did not switch on below its ON threshold.");

  a_upper_release: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && on_thr_i[2] == off_thr_i[2] && value_i[2] < off_thr_i[2] |=> !lim_q[2])
    else $error("Equal-threshold limit did not release below the threshold.");

  a_limit_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !eval |=> $stable(lim_q) && $stable(y_q) && $stable(z_q) && $stable(a_q))
    else $error("A state changed outside an evaluation pass.");

  a_hour_run: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && lim_d[2] |=> hour_run_o[2])
    else $error("Hour counter enable did not follow its limit.");

  a_gap_bound: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    gap_q < GAP_W'(MAX_GAP_CYCLES))
    else $error("Evaluation gap exceeded its longest spacing.");

  a_follow_inv: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    eval ##1 !eval |-> s_q == (a_q ^ $past(follow_inv_i, 1)))
    else $error("Follow-up state disagrees with the output state.");

  a_alarm_latch: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && latch_en_i[3] && a_q[3] && !rst_now |=> a_q[3])
    else $error("Latched alarm dropped without a reset request.");

  a_alarm_plain: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && !latch_en_i[3] |=> a_q[3] == d_cur[3])
    else $error("Unlatched output does not follow its delayed state.");

  a_upper_off: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && on_thr_i[0] > off_thr_i[0] && value_i[0] < off_thr_i[0] |=> !lim_q[0])
    else $error("Upper limit did not switch off below its OFF threshold.");

  a_lower_release: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && on_thr_i[1] < off_thr_i[1] && value_i[1] > off_thr_i[1] |=> !lim_q[1])
    else $error("Lower limit did not switch off above its OFF threshold.");

  // Single-input OR gates make the routing visible, since the result must copy its source.
  a_chain_direct: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && l1_sel_i[1][0] == SRC_FIRST && $onehot(l1_used_i[1]) && l1_used_i[1][0] &&
    l1_type_i[1] == G_OR |=> y_q[1] == y_q[0])
    else $error("A later first-level gate missed an earlier result of the same pass.");

  a_feedback_late: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && l1_sel_i[2][0] == SRC_FIRST + SEL_W'(N_CH - 1) && $onehot(l1_used_i[2]) &&
    l1_used_i[2][0] && l1_type_i[2] == G_OR |=> y_q[2] == $past(y_q[N_CH-1]))
    else $error("A fed-back first-level state took effect in the same pass.");

  a_second_order: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && l2_sel_i[1][0] == SRC_FIRST && $onehot(l2_used_i[1]) && l2_used_i[1][0] &&
    l2_type_i[1] == G_OR |=> z_q[1] == y_q[0])
    else $error("A second-level gate did not see this pass's first-level state.");

  a_delay_order: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && rise_dly_i[1] == '0 && fall_dly_i[1] == '0 |=> d_cur[1] == z_q[1])
    else $error("A zero-delay state did not follow its second-level state.");

  a_alarm_reset: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && latch_en_i[3] && rst_now && !d_d[3] |=> !a_q[3])
    else $error("Latched alarm survived a reset request.");

  a_reset_pending: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    alarm_rst_req_i && !eval |=> rst_pend_q)
    else $error("Alarm reset request was not held for the next pass.");

  a_gap_restart: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !tick_i && gap_q == GAP_W'(MAX_GAP_CYCLES - 1) |=> gap_q == '0)
    else $error("Forced pass did not restart the gap count.");

  c_upper_trip: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    !lim_q[0] ##1 lim_q[0]);

  c_alarm_latched: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    latch_en_i[3] && a_q[3] && !d_cur[3]);

  c_gap_tick: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && !tick_i);

  c_chain_same_pass: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    eval && l1_sel_i[1][0] == SRC_FIRST && y_d[0] != y_q[0]);

  c_alarm_reset: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    latch_en_i[3] && a_q[3] ##1 !a_q[3]);

endmodule

// >>> rtl/limit_logic_pkg.sv
// Constants, types and field layouts shared by the limit logic evaluator and its delay units.
// Assumes a single 40 MHz clock domain and an evaluation tick once per power-frequency cycle.
// Notes on behaviour
// - Gate type: AND, OR, XOR or inversions.
// - XOR: exactly one; XNOR: all same.
// - First level three inputs, second level four.
// - Unused inputs take the gate's neutral value.
// - Upper limit: on above ON, off below OFF.
// - Lower limit: on below ON, off above OFF.
// - Equal thresholds act as upper, no hysteresis.
// - Hour counter runs while its limit is true.
// - Pass order: first, second, delayed, output states.
// - One pass per cycle, never over 25 ms apart.
// - Fed-back states count in the next pass.
// - Earlier first-level results feed later ones directly.
// - Delayed state follows with switch-in/dropout delays.
// - Follow-up state is output, optionally inverted.
// - Enabled alarm latches until a reset request.
package limit_logic_pkg;

  localparam int unsigned N_CH       = 4;
  localparam int unsigned N_LIM      = 4;
  localparam int unsigned N_DIN      = 4;
  localparam int unsigned L1_INPUTS  = 3;
  localparam int unsigned L2_INPUTS  = 4;
  localparam int unsigned SEL_W      = 5;
  localparam int unsigned N_SRC      = 32;
  localparam int unsigned VAL_W      = 16;
  localparam int unsigned DLY_W      = 16;
  localparam int unsigned GAP_W      = 20;

  // Source index layout of the gate input selectors; indices 24 to 31 read as false.
  localparam logic [SEL_W-1:0] SRC_LIMIT   = 5'h00;
  localparam logic [SEL_W-1:0] SRC_DIGIN   = 5'h04;
  localparam logic [SEL_W-1:0] SRC_FIRST   = 5'h08;
  localparam logic [SEL_W-1:0] SRC_SECOND  = 5'h0C;
  localparam logic [SEL_W-1:0] SRC_DELAYED = 5'h10;
  localparam logic [SEL_W-1:0] SRC_OUTPUT  = 5'h14;
  localparam logic [7:0]       SRC_UNUSED  = 8'h00;

  localparam int unsigned CLK_HZ       = 40000000;
  localparam int unsigned MAX_GAP_MS   = 25;
  // Longest time rounds down to whole cycles.
  localparam int unsigned MAX_GAP_CYC  = (CLK_HZ / 1000) * MAX_GAP_MS;

  typedef enum logic [2:0] {
    G_AND  = 3'h0,
    G_OR   = 3'h1,
    G_XOR  = 3'h2,
    G_NAND = 3'h3,
    G_NOR  = 3'h4,
    G_XNOR = 3'h5
  } gate_t;

  typedef logic [N_CH-1:0][L1_INPUTS-1:0][SEL_W-1:0] l1_sel_t;
  typedef logic [N_CH-1:0][L2_INPUTS-1:0][SEL_W-1:0] l2_sel_t;
  typedef logic [N_CH-1:0][L1_INPUTS-1:0]            l1_used_t;
  typedef logic [N_CH-1:0][L2_INPUTS-1:0]            l2_used_t;
  typedef gate_t [N_CH-1:0]                          gate_vec_t;
  typedef logic [N_LIM-1:0][VAL_W-1:0]               val_vec_t;
  typedef logic [N_CH-1:0][DLY_W-1:0]                dly_vec_t;

endpackage

// >>> test/limit_logic_evaluator_tb_top.sv
// Self-checking bench for the limit logic evaluator, driven through its plain ports.
// Assumes the design package is compiled first; inputs change on falling clock edges.
module limit_logic_evaluator_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import limit_logic_pkg::*;

  // Long enough that no forced pass slips between the ticks that the tests give.
  localparam int unsigned GAP = 2000;

  logic                  mclk_i;
  logic                  resetn_i;
  logic                  tick_i;
  val_vec_t              value_i;
  val_vec_t              on_thr_i;
  val_vec_t              off_thr_i;
  logic [N_DIN-1:0]      digin_i;
  gate_vec_t             l1_type_i;
  l1_sel_t               l1_sel_i;
  l1_used_t              l1_used_i;
  gate_vec_t             l2_type_i;
  l2_sel_t               l2_sel_i;
  l2_used_t              l2_used_i;
  dly_vec_t              rise_dly_i;
  dly_vec_t              fall_dly_i;
  logic [N_CH-1:0]       latch_en_i;
  logic [N_CH-1:0]       follow_inv_i;
  logic                  alarm_rst_req_i;
  logic                  rst_int_en_i;
  logic [SEL_W-1:0]      rst_int_sel_i;
  logic [N_LIM-1:0]      limit_state_o;
  logic [N_LIM-1:0]      hour_run_o;
  logic [N_CH-1:0]       first_level_state_o;
  logic [N_CH-1:0]       second_level_state_o;
  logic [N_CH-1:0]       delayed_state_o;
  logic [N_CH-1:0]       output_state_o;
  logic [N_CH-1:0]       follow_state_o;
  logic                  eval_o;
  int                    mismatches = 0;
  int                    n_checks = 0;

  limit_logic_evaluator #(.MAX_GAP_CYCLES(GAP)) i_limit_logic_evaluator (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .tick_i(tick_i), .value_i(value_i),
    .on_thr_i(on_thr_i), .off_thr_i(off_thr_i), .digin_i(digin_i),
    .l1_type_i(l1_type_i), .l1_sel_i(l1_sel_i), .l1_used_i(l1_used_i),
    .l2_type_i(l2_type_i), .l2_sel_i(l2_sel_i), .l2_used_i(l2_used_i),
    .rise_dly_i(rise_dly_i), .fall_dly_i(fall_dly_i), .latch_en_i(latch_en_i),
    .follow_inv_i(follow_inv_i), .alarm_rst_req_i(alarm_rst_req_i),
    .rst_int_en_i(rst_int_en_i), .rst_int_sel_i(rst_int_sel_i),
    .limit_state_o(limit_state_o), .hour_run_o(hour_run_o),
    .first_level_state_o(first_level_state_o), .second_level_state_o(second_level_state_o),
    .delayed_state_o(delayed_state_o), .output_state_o(output_state_o),
    .follow_state_o(follow_state_o), .eval_o(eval_o));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic end_of_test;
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Every gate defaults to an OR with no used input, which reads false.
  task automatic clear_cfg;
    value_i = '0; on_thr_i = '0; off_thr_i = '0; digin_i = '0;
    l1_sel_i = '0; l1_used_i = '0; l2_sel_i = '0; l2_used_i = '0;
    rise_dly_i = '0; fall_dly_i = '0; latch_en_i = '0; follow_inv_i = '0;
    alarm_rst_req_i = 1'b0;
    for (int c = 0; c < N_CH; c++) begin
      l1_type_i[c] = G_OR;
      l2_type_i[c] = G_OR;
    end
  endtask

  task automatic do_pass;
    @(negedge mclk_i);
    tick_i = 1'b1;
    @(negedge mclk_i);
    tick_i = 1'b0;
  endtask

  // Digital inputs need four edges before a pass sees them.
  task automatic settle_pass;
    repeat (5) @(negedge mclk_i);
    do_pass();
  endtask

  function automatic logic gexp(int t, logic [2:0] x, logic [2:0] m);
    int ones = 0;
    int n = 0;
    for (int k = 0; k < 3; k++) begin
      if (m[k]) begin
        n++;
        ones += int'(x[k]);
      end
    end
    case (t)
      0: return ones == n;
      1: return ones > 0;
      2: return ones == 1;
      3: return ones != n;
      4: return ones == 0;
      default: return (ones == n) || (ones == 0);
    endcase
  endfunction

  task automatic t_limits;
    logic [15:0] v0 [4] = '{16'h005A, 16'h0065, 16'h0055, 16'h004F};
    logic [15:0] v1 [4] = '{16'h003C, 16'h0031, 16'h0041, 16'h0047};
    logic [15:0] v2 [4] = '{16'h003D, 16'h003C, 16'h003B, 16'h003B};
    logic [3:0]  ex [4] = '{4'h4, 4'h7, 4'h3, 4'h0};
    clear_cfg();
    on_thr_i[0] = 16'h0064; off_thr_i[0] = 16'h0050;
    on_thr_i[1] = 16'h0032; off_thr_i[1] = 16'h0046;
    on_thr_i[2] = 16'h003C; off_thr_i[2] = 16'h003C;
    for (int i = 0; i < 4; i++) begin
      value_i[0] = v0[i]; value_i[1] = v1[i]; value_i[2] = v2[i];
      do_pass();
      chk(limit_state_o, ex[i]);
      chk(hour_run_o, ex[i]);
    end
  endtask

  task automatic t_gates;
    logic [2:0] m;
    logic       e;
    clear_cfg();
    for (int k = 0; k < 3; k++) l1_sel_i[0][k] = SRC_DIGIN + 5'(k);
    for (int k = 0; k < 4; k++) l2_sel_i[0][k] = SRC_DIGIN + 5'(k);
    l2_type_i[0] = G_AND; l2_used_i[0] = 4'hF;
    l2_sel_i[1][0] = SRC_FIRST; l2_used_i[1] = 4'h1;
    for (int p = 0; p < 2; p++) begin
      m = (p == 0) ? 3'h7 : 3'h3;
      l1_used_i[0] = m;
      for (int t = 0; t < 6; t++) begin
        l1_type_i[0] = gate_t'(t);
        for (int v = 0; v < 8; v++) begin
          digin_i = {1'b1, 3'(v)};
          e = gexp(t, 3'(v), m);
          settle_pass();
          chk(first_level_state_o[0], e);
          chk(second_level_state_o[0], &3'(v));
          chk(second_level_state_o[1], e);
          chk(output_state_o[1], e);
        end
      end
    end
  endtask

  task automatic t_feedback;
    clear_cfg();
    l1_sel_i[0][0] = SRC_DIGIN; l1_used_i[0] = 3'h1;
    l1_sel_i[1][0] = SRC_FIRST; l1_used_i[1] = 3'h1;
    l1_sel_i[2][0] = SRC_FIRST + 5'h03; l1_used_i[2] = 3'h1;
    l1_sel_i[3][0] = SRC_DIGIN; l1_used_i[3] = 3'h1;
    digin_i[0] = 1'b1;
    settle_pass();
    chk(first_level_state_o, 4'hB);
    do_pass();
    chk(first_level_state_o, 4'hF);
    digin_i[0] = 1'b0;
    settle_pass();
    chk(first_level_state_o, 4'h4);
  endtask

  task automatic t_delay;
    clear_cfg();
    l2_sel_i[2][0] = SRC_DIGIN + 5'h01; l2_used_i[2] = 4'h1;
    rise_dly_i[2] = 16'h0002; fall_dly_i[2] = 16'h0003;
    digin_i[1] = 1'b1;
    for (int i = 0; i < 3; i++) begin
      settle_pass();
      chk(delayed_state_o[2], i == 2);
    end
    digin_i[1] = 1'b0;
    for (int i = 0; i < 4; i++) begin
      settle_pass();
      chk(delayed_state_o[2], i < 3);
    end
  endtask

  task automatic t_latch;
    clear_cfg();
    l2_sel_i[3][0] = SRC_DIGIN + 5'h02; l2_used_i[3] = 4'h1;
    latch_en_i[3] = 1'b1; follow_inv_i[3] = 1'b1;
    digin_i[2] = 1'b1;
    settle_pass();
    chk({output_state_o[3], follow_state_o[3]}, 16'h0002);
    digin_i[2] = 1'b0;
    settle_pass();
    chk({output_state_o[3], delayed_state_o[3]}, 16'h0002);
    alarm_rst_req_i = 1'b1;
    @(negedge mclk_i);
    alarm_rst_req_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    do_pass();
    chk({output_state_o[3], follow_state_o[3]}, 16'h0001);
    // A latched alarm also clears from an internal source, here digital input one.
    digin_i[2] = 1'b1;
    settle_pass();
    chk(output_state_o[3], 1'b1);
    digin_i = 4'h2;
    rst_int_en_i = 1'b1;
    rst_int_sel_i = SRC_DIGIN + 5'h01;
    settle_pass();
    chk(output_state_o[3], 1'b0);
    rst_int_en_i = 1'b0;
    // A reset in mid-run must clear a freshly raised alarm.
    digin_i[2] = 1'b1;
    settle_pass();
    resetn_i = 1'b0;
    @(negedge mclk_i);
    chk({limit_state_o, first_level_state_o}, 16'h0000);
    chk({second_level_state_o, delayed_state_o}, 16'h0000);
    chk({output_state_o, follow_state_o}, 16'h0000);
    resetn_i = 1'b1;
    @(negedge mclk_i);
    chk({limit_state_o, delayed_state_o, output_state_o, follow_state_o}, 16'h0000);
  endtask

  task automatic t_gap;
    int n = 0;
    clear_cfg();
    while (eval_o !== 1'b1 && n < 3 * GAP) begin
      @(negedge mclk_i);
      n++;
    end
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (eval_o !== 1'b1 && n < 3 * GAP);
    chk(16'(n), 16'(GAP));
  endtask

  initial begin
    clear_cfg();
    tick_i = 1'b0;
    resetn_i = 1'b0;
    rst_int_en_i = 1'b0;
    rst_int_sel_i = '0;
    repeat (5) @(negedge mclk_i);
    resetn_i = 1'b1;
    @(negedge mclk_i);
    chk({limit_state_o, first_level_state_o}, 16'h0000);
    chk({second_level_state_o, output_state_o}, 16'h0000);
    t_limits();
    t_gates();
    t_feedback();
    t_delay();
    t_latch();
    t_gap();
    end_of_test();
  end

  initial begin
    #500000;
    mismatches++;
    end_of_test();
  end
endmodule
